// >>> dv/repeater_port_port_administration_status_regs_test.sv
/*
 Self-checking bench of the port administration register bank.
 Assumes the map header on the include path and the agent model beside it.
*/
`default_nettype none
`include "rpa_map.svh"

module repeater_port_port_administration_status_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock_in, rst_in, reg_write, reg_read, reg_rvalid;
	logic [4:0] reg_addr, strap, id_out;
	logic [15:0] reg_wdata, reg_rdata;
	logic [11:0] port_partitioned_flag_set, jab_set, port_en, led_en, pm, jm, dis;
	logic idle, rx_valid, eeprom_load_complete, conflict, sfd, act_n, dv_n, dclk;
	logic [3:0] rx_num;
	logic [31:0] seed;
	int error_cnt, n_tests, i;

	rpa_mgmt_agent u_agent (.clock_in(clock_in), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_write_out(reg_write), .reg_read_out(reg_read));

	rpa_port_port_administration_status u_dut (.clock_in(clock_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
		.reg_read_in(reg_read), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
		.port_partitioned_flag_set_in(port_partitioned_flag_set), .port_jabber_flag_set_in(jab_set),
		.network_idle_in(idle), .rx_port_valid_in(rx_valid), .rx_port_num_in(rx_num),
		.eeprom_load_complete_in(eeprom_load_complete), .identifier_conflict_in(conflict),
		.sfd_seen_in(sfd), .interrepeater_activity_n_in(act_n),
		.interrepeater_data_valid_n_in(dv_n), .interrepeater_data_clock_in(dclk),
		.repeater_identifier_in(strap), .port_enable_out(port_en),
		.partition_led_enable_out(led_en), .repeater_id_field_out(id_out));

	// Free-running 100 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	// Xorshift generator for stimulus values
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// Identification word layout
	function automatic logic [15:0] dev(input int fp, input logic [3:0] pn, input int ee,
			input int er, input logic [4:0] id);
		return {3'h0, fp[0], pn, ee[0], 1'b0, er[0], id};
	endfunction : dev

	// Single comparison point
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Verdict and stop
	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Activity frame: some data clock rises, then valid with start delimiter
	task automatic ir_frame(input int rises);
		int k;
		@(posedge clock_in);
		act_n <= 1'b0;
		repeat (8) @(posedge clock_in);
		for (k = 0; k < rises; k++) begin
			dclk <= 1'b1;
			repeat (6) @(posedge clock_in);
			dclk <= 1'b0;
			repeat (6) @(posedge clock_in);
		end
		dv_n <= 1'b0;
		sfd <= 1'b1;
		repeat (12) @(posedge clock_in);
		{sfd, act_n, dv_n} <= 3'h3;
		repeat (10) @(posedge clock_in);
	endtask : ir_frame

	// Read monitor: oldest note against each answer, settled at the falling edge
	always @(negedge clock_in) begin
		if (reg_rvalid === 1'b1) begin
			if (u_agent.exp_q.size() > 0) begin
				check(reg_rdata, u_agent.exp_q.pop_front());
			end else begin
				check(reg_rdata, 'x);
			end
		end
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		$display("MISMATCH t=%0t timeout", $time);
		end_of_test();
	end

	// Main sequence
	initial begin
		seed = xs(32'h00005E69); // Start value 24169
		strap = (seed[4:0] == 5'h1F) ? 5'h1E : seed[4:0];
		{rst_in, act_n, dv_n} = 3'h7;
		{idle, rx_valid, eeprom_load_complete, conflict, sfd, dclk} = 6'h00;
		{port_partitioned_flag_set, jab_set, rx_num} = 28'h0;
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge clock_in);
		u_agent.rd(`RPA_OFF_PAGE, 16'h0000);
		u_agent.rd(`RPA_OFF_PORT_PARTITIONED_FLAG, 16'h0000);
		u_agent.rd(`RPA_OFF_JAB, 16'h0000);
		u_agent.rd(`RPA_OFF_PORT_ADMINISTRATION, 16'h0000);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h0, 0, 0, strap));
		#1 check({4'h0, port_en}, 16'h0FFF);
		check({11'h0, id_out}, {11'h0, strap});
		seed = xs(seed);
		{jm, pm} = seed[23:0];
		@(posedge clock_in);
		port_partitioned_flag_set <= pm;
		jab_set <= jm;
		@(posedge clock_in);
		port_partitioned_flag_set <= 12'h000;
		jab_set <= 12'h000;
		u_agent.wr(`RPA_OFF_PORT_PARTITIONED_FLAG, 16'hFFFF, 0);
		u_agent.wr(`RPA_OFF_JAB, 16'h0000, 0);
		u_agent.rd(`RPA_OFF_PORT_PARTITIONED_FLAG, {4'h0, pm});
		u_agent.rd(`RPA_OFF_JAB, {4'h0, jm});
		// disables wait for idle, LED test follows
		seed = xs(seed);
		dis = seed[11:0] | 12'h001;
		u_agent.wr(`RPA_OFF_PORT_ADMINISTRATION, {4'hF, dis}, 0);
		u_agent.rd(`RPA_OFF_PORT_ADMINISTRATION, {4'h1, dis});
		#1 check({4'h0, port_en}, 16'h0FFF);
		check({4'h0, led_en}, {4'h0, dis});
		@(posedge clock_in);
		idle <= 1'b1;
		repeat (2) @(posedge clock_in);
		#1 check({4'h0, port_en}, {4'h0, ~dis});
		u_agent.wr(`RPA_OFF_PORT_ADMINISTRATION, 16'h0000, 1);
		repeat (2) @(posedge clock_in);
		#1 check({4'h0, port_en}, 16'h0FFF);
		check({4'h0, led_en}, 16'h0000);
		// pages 1 to 3, only address 1 mapped off page 0
		for (i = 1; i < 4; i++) begin
			u_agent.wr(`RPA_OFF_PAGE, 16'hFFFC | i[15:0], 0);
			u_agent.rd(`RPA_OFF_PAGE, {14'h0, i[1:0]});
			u_agent.wr(`RPA_OFF_PORT_ADMINISTRATION, 16'h0FFF, 1);
			u_agent.rd(`RPA_OFF_PORT_ADMINISTRATION, 16'h0000);
		end
		u_agent.wr(`RPA_OFF_PAGE, 16'h0000, 1);
		u_agent.rd(`RPA_OFF_PORT_ADMINISTRATION, 16'h0000);
		u_agent.rd(5'h07, 16'h0000);
		@(posedge clock_in);
		{rx_valid, rx_num, eeprom_load_complete, conflict} <= {1'b1, 4'h9, 2'h3};
		@(posedge clock_in);
		{rx_valid, rx_num, eeprom_load_complete, conflict} <= {1'b0, 4'h3, 2'h0};
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 1, strap));
		u_agent.wr(`RPA_OFF_DEVID, 16'h0F80 | strap, 0);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 0, strap));
		u_agent.wr(`RPA_OFF_DEVID, 16'h001F, 1);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 1, 5'h1F));
		#1 check({11'h0, id_out}, 16'h001F);
		u_agent.wr(`RPA_OFF_DEVID, {11'h0, strap}, 1);
		u_agent.wr(`RPA_OFF_DEVID, {11'h0, strap}, 1);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 0, strap));
		// valid five data clocks after activity, then sticky
		ir_frame(5);
		u_agent.rd(`RPA_OFF_DEVID, dev(1, 4'h9, 1, 0, strap));
		repeat (20) @(posedge clock_in);
		u_agent.rd(`RPA_OFF_DEVID, dev(1, 4'h9, 1, 0, strap));
		u_agent.wr(`RPA_OFF_DEVID, {11'h0, strap}, 1);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 0, strap));
		// valid after only two data clocks is no detection
		ir_frame(2);
		u_agent.rd(`RPA_OFF_DEVID, dev(0, 4'h9, 1, 0, strap));
		// Every noted read must have been answered
		repeat (3) @(posedge clock_in);
		if (u_agent.exp_q.size() != 0) begin
			error_cnt++;
			$display("MISMATCH t=%0t unanswered reads", $time);
		end
		end_of_test();
	end
endmodule : repeater_port_port_administration_status_regs_test
`default_nettype wire

// >>> dv/rpa_mgmt_agent.sv
/*
 Management agent model: issues decoded register reads and writes to the
 port administration bank and notes each expected read word in a queue.
 Assumes it shares the bank's clock and that callers resume just after an edge.
*/
`default_nettype none
`include "rpa_map.svh"

module rpa_mgmt_agent (
	input wire logic clock_in,
	output logic [`RPA_ADDR_W-1:0] reg_addr_out,
	output logic [`RPA_DATA_W-1:0] reg_wdata_out,
	output logic reg_write_out,
	output logic reg_read_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [`RPA_DATA_W-1:0] exp_q[$];

	// Quiet bus at time zero
	initial begin
		reg_addr_out = 5'h00;
		reg_wdata_out = 16'h0000;
		reg_write_out = 1'b0;
		reg_read_out = 1'b0;
	end

	// One write strobe; released lines are scrambled so stale data never helps
	task automatic wr(input logic [4:0] a, input logic [15:0] d, input int clean);
		logic [15:0] m;
		m = (a == `RPA_OFF_PAGE) ? 16'h0003 : 16'h1FFF;
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_wdata_out <= (clean != 0) ? (d & m) : d;
		reg_write_out <= 1'b1;
		@(posedge clock_in);
		reg_write_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask : wr

	// One read strobe, expected word noted first
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge clock_in);
		reg_addr_out <= a;
		reg_read_out <= 1'b1;
		@(posedge clock_in);
		reg_read_out <= 1'b0;
		reg_addr_out <= ~a;
	endtask : rd
endmodule : rpa_mgmt_agent
`default_nettype wire

// >>> rtl/rpa_det_if.sv
/*
 Carrier between the register bank and its four-pair detector.
 Assumes both ends run on the same clock.
*/
`default_nettype none

interface rpa_det_if;
	logic act;
	logic dv;
	logic clk_rise;
	logic sfd;
	logic hit;

	modport src (output act, output dv, output clk_rise, output sfd, input hit);
	modport det (input act, input dv, input clk_rise, input sfd, output hit);
endinterface : rpa_det_if

`default_nettype wire

// >>> rtl/rpa_four_pair_detect.sv
/*
 Four-pair PHY detector: watches the filtered inter-repeater signals and
 pulses hit once per activity period that meets the timing criterion.
 Assumes the inputs are already synchronised to clock_in.
*/
`default_nettype none
`include "rpa_map.svh"

module rpa_four_pair_detect
	import rpa_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	rpa_det_if.det det_bus
);

	rpa_det_state_t state_reg, state_next;
	logic [`RPA_FPD_CNT_W-1:0] cnt_reg, cnt_next;
	logic hit_reg, hit_next;
	logic in_window;

	assign in_window = (cnt_reg >= `RPA_FPD_MIN) && (cnt_reg <= `RPA_FPD_MAX);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		hit_next = 1'b0;
		case (state_reg)
			RPA_DET_IDLE: begin
				if (det_bus.act) begin
					state_next = RPA_DET_COUNT;
					cnt_next = '0;
				end
			end
			RPA_DET_COUNT: begin
				if (!det_bus.act) begin
					state_next = RPA_DET_IDLE;
				end else if (det_bus.dv) begin
					state_next = in_window ? RPA_DET_SFD : RPA_DET_DONE;
				end else if (cnt_reg > `RPA_FPD_MAX) begin
					state_next = RPA_DET_DONE;
				end else if (det_bus.clk_rise) begin
					cnt_next = cnt_reg + 3'h1;
				end
			end
			RPA_DET_SFD: begin
				if (!det_bus.act) begin
					state_next = RPA_DET_IDLE;
				end else if (det_bus.sfd) begin
					hit_next = 1'b1;
					state_next = RPA_DET_DONE;
				end
			end
			RPA_DET_DONE: begin
				if (!det_bus.act) begin
					state_next = RPA_DET_IDLE;
				end
			end
			default: begin
				state_next = RPA_DET_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= RPA_DET_IDLE;
			cnt_reg <= '0;
			hit_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			hit_reg <= hit_next;
		end
	end

	assign det_bus.hit = hit_reg;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sequence s_valid_in_window;
		state_reg == RPA_DET_COUNT && det_bus.act && det_bus.dv && in_window;
	endsequence

	sequence s_sfd_seen;
		det_bus.act && det_bus.sfd;
	endsequence

	chk_detect_window: assert property (s_valid_in_window ##1 s_sfd_seen |=> hit_reg)
		else $error("four-pair hit missing after valid in window and sfd");
	chk_detect_late: assert property ((state_reg == RPA_DET_COUNT && det_bus.act
			&& det_bus.dv && !in_window) |=> !hit_reg ##1 !hit_reg)
		else $error("four-pair hit on valid outside window");
	chk_detect_cause: assert property (hit_reg |-> $past(state_reg) == RPA_DET_SFD)
		else $error("four-pair hit without sfd stage");

endmodule : rpa_four_pair_detect

`default_nettype wire

// >>> rtl/rpa_map.svh
/*
 Register offsets, field positions, reset values and counts of the port
 administration and status register bank. Assumes inclusion by bare name.
*/
`ifndef RPA_MAP_SVH
`define RPA_MAP_SVH

// Bus and port widths
`define RPA_ADDR_W 5
`define RPA_DATA_W 16
`define RPA_PORTS 12
`define RPA_ID_W 5
`define RPA_PNUM_W 4

// Register offsets
`define RPA_OFF_PAGE 5'h01
`define RPA_OFF_PORT_PARTITIONED_FLAG 5'h02
`define RPA_OFF_JAB 5'h03
`define RPA_OFF_PORT_ADMINISTRATION 5'h04
`define RPA_OFF_DEVID 5'h05

// Page encodings
`define RPA_PAGE_0 2'h0
`define RPA_PAGE_1 2'h1
`define RPA_PAGE_RST 2'h0

// Field positions
`define RPA_BIT_LED_TEST 12
`define RPA_BIT_FOUR_PAIR 12
`define RPA_PNUM_LSB 8
`define RPA_BIT_EEPROM_LOAD_COMPLETE 7
`define RPA_BIT_ID_ERR 5

// Reset values
`define RPA_FLAGS_RST 12'h000
`define RPA_ENABLE_RST 12'hFFF
`define RPA_ID_RST 5'h00
`define RPA_PNUM_RST 4'h0
`define RPA_ID_ILLEGAL 5'h1F

// Four-pair detection window, in data clock edges after activity
`define RPA_FPD_CNT_W 3
`define RPA_FPD_MIN 3'h4
`define RPA_FPD_MAX 3'h6

// Clock edges after reset release before straps are caught
`define RPA_STRAP_SETTLE 3'h5

`endif

// >>> rtl/rpa_pkg.sv
/*
 Types and shared decode for the port administration register bank.
 Assumes the map header is on the include path.
*/
`default_nettype none
`include "rpa_map.svh"

package rpa_pkg;

	typedef logic [`RPA_PORTS-1:0] rpa_port_vec_t;

	typedef enum logic [1:0] {
		RPA_DET_IDLE = 2'h0,
		RPA_DET_COUNT = 2'h1,
		RPA_DET_SFD = 2'h2,
		RPA_DET_DONE = 2'h3
	} rpa_det_state_t;

	// Register select: the page register answers on every page
	function automatic logic rpa_reg_sel(input logic [`RPA_ADDR_W-1:0] addr,
			input logic [1:0] page, input logic [`RPA_ADDR_W-1:0] off);
		return (addr == off) && ((off == `RPA_OFF_PAGE) || (page == `RPA_PAGE_0));
	endfunction : rpa_reg_sel

endpackage : rpa_pkg
`default_nettype wire

// >>> rtl/rpa_port_port_administration_status.sv
/*
 Port administration and status register bank of a twelve-port repeater:
 page select, partition and jabber flags, administrative disables with a
 partition LED test, and the device identification register.
 Assumes a serial register front end that presents one decoded read or
 write per clock, and same-clock event strobes from the port logic.
*/
// How it works
// - Two-bit page field selects page 0 or 1; 2 and 3 reserved; resets to 0.
// - Page register answers at address 1 on every page.
// - Partition flags at page 0 address 2, set by port logic, reset clears.
// - Jabber flags at page 0 address 3 bits 11..0, set by port logic, reset clears.
// - Bits 15..12 of partition and jabber registers carry no value; read zero.
// - Twelve port_administration disable bits at address 4; one disables a port.
// - Port_administration enable changes reach the ports only at the next network idle.
// - After reset all port_administration disable bits are zero, every port enabled.
// - LED test bit enables partition LEDs of administratively disabled ports.
// - Four-pair flag sets when valid follows activity by about five data clocks.
// - Four-pair flag stays set until an identification write with bit 12 zero or reset clears it.
// - Identification bits 11..8 report current or last receiving port.
// - Identification bit 7 sets once the EEPROM read completes.
// - Identifier bits 4..0 load from straps after reset and drive bus address.
// - Identifier error flag sticks on conflict or all-ones identifier until written.
`default_nettype none
`include "rpa_map.svh"

module rpa_port_port_administration_status
	import rpa_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [`RPA_ADDR_W-1:0] reg_addr_in,
	input wire logic [`RPA_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [`RPA_DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic [`RPA_PORTS-1:0] port_partitioned_flag_set_in,
	input wire logic [`RPA_PORTS-1:0] port_jabber_flag_set_in,
	input wire logic network_idle_in,
	input wire logic rx_port_valid_in,
	input wire logic [`RPA_PNUM_W-1:0] rx_port_num_in,
	input wire logic eeprom_load_complete_in,
	input wire logic identifier_conflict_in,
	input wire logic sfd_seen_in,
	input wire logic interrepeater_activity_n_in,
	input wire logic interrepeater_data_valid_n_in,
	input wire logic interrepeater_data_clock_in,
	input wire logic [`RPA_ID_W-1:0] repeater_identifier_in,
	output logic [`RPA_PORTS-1:0] port_enable_out,
	output logic [`RPA_PORTS-1:0] partition_led_enable_out,
	output logic [`RPA_ID_W-1:0] repeater_id_field_out
);

	localparam int PIN_W = 8;
	localparam int P_ACT = 7;
	localparam int P_DV = 6;
	localparam int P_CLK = 5;

	// Pin synchroniser and strap capture state
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic clk_rise_reg, clk_rise_next;
	logic [2:0] settle_reg, settle_next;
	logic strap_done_reg, strap_done_next;

	// Register state
	logic [1:0] page_reg, page_next;
	rpa_port_vec_t port_partitioned_flag_reg, port_partitioned_flag_next;
	rpa_port_vec_t jab_reg, jab_next;
	rpa_port_vec_t dis_reg, dis_next;
	logic led_test_reg, led_test_next;
	rpa_port_vec_t enable_reg, enable_next;
	rpa_port_vec_t led_reg, led_next;
	logic four_pair_reg, four_pair_next;
	logic [`RPA_PNUM_W-1:0] pnum_reg, pnum_next;
	logic eeprom_load_complete_reg, eeprom_load_complete_next;
	logic id_err_reg, id_err_next;
	logic [`RPA_ID_W-1:0] id_reg, id_next;
	logic [`RPA_DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic wr_page, wr_port_administration, wr_devid;

	rpa_det_if det_bus();

	rpa_four_pair_detect u_detect (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.det_bus(det_bus)
	);

	assign pins = {interrepeater_activity_n_in, interrepeater_data_valid_n_in,
		interrepeater_data_clock_in, repeater_identifier_in};

	// Filter takes a pin level once the second and third stages agree
	always_comb begin
		filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
		clk_rise_next = filt_next[P_CLK] & ~filt_reg[P_CLK];
		settle_next = (settle_reg == `RPA_STRAP_SETTLE) ? settle_reg : settle_reg + 3'h1;
		strap_done_next = strap_done_reg | (settle_reg == `RPA_STRAP_SETTLE);
	end

	// Synchroniser registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			// Stages start at the idle level so no false activity follows reset
			s1_reg <= {PIN_W{1'b1}};
			s2_reg <= {PIN_W{1'b1}};
			s3_reg <= {PIN_W{1'b1}};
			filt_reg <= {PIN_W{1'b1}};
			clk_rise_reg <= 1'b0;
			settle_reg <= 3'h0;
			strap_done_reg <= 1'b0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			clk_rise_reg <= clk_rise_next;
			settle_reg <= settle_next;
			strap_done_reg <= strap_done_next;
		end
	end

	// Detector inputs, active high
	assign det_bus.act = ~filt_reg[P_ACT];
	assign det_bus.dv = ~filt_reg[P_DV];
	assign det_bus.clk_rise = clk_rise_reg;
	assign det_bus.sfd = sfd_seen_in;

	// page-independent decode of the page register
	assign wr_page = reg_write_in && rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_PAGE);
	assign wr_port_administration = reg_write_in && rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_PORT_ADMINISTRATION);
	assign wr_devid = reg_write_in && rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_DEVID);

	// Register bank next values
	always_comb begin
		page_next = wr_page ? reg_wdata_in[1:0] : page_reg;
		port_partitioned_flag_next = port_partitioned_flag_reg | port_partitioned_flag_set_in;
		jab_next = jab_reg | port_jabber_flag_set_in;
		dis_next = wr_port_administration ? reg_wdata_in[`RPA_PORTS-1:0] : dis_reg;
		led_test_next = wr_port_administration ? reg_wdata_in[`RPA_BIT_LED_TEST] : led_test_reg;
		enable_next = network_idle_in ? ~dis_reg : enable_reg;
		led_next = {`RPA_PORTS{led_test_reg}} & dis_reg;
		four_pair_next = wr_devid ? reg_wdata_in[`RPA_BIT_FOUR_PAIR] : four_pair_reg;
		four_pair_next = four_pair_next | det_bus.hit;
		pnum_next = rx_port_valid_in ? rx_port_num_in : pnum_reg;
		eeprom_load_complete_next = eeprom_load_complete_reg | eeprom_load_complete_in;
		id_next = wr_devid ? reg_wdata_in[`RPA_ID_W-1:0] : id_reg;
		if (!strap_done_reg && settle_reg == `RPA_STRAP_SETTLE) begin
			id_next = filt_reg[`RPA_ID_W-1:0];
		end
		id_err_next = wr_devid ? reg_wdata_in[`RPA_BIT_ID_ERR] : id_err_reg;
		id_err_next = id_err_next | identifier_conflict_in | (id_reg == `RPA_ID_ILLEGAL);
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			page_reg <= `RPA_PAGE_RST;
			port_partitioned_flag_reg <= `RPA_FLAGS_RST;
			jab_reg <= `RPA_FLAGS_RST;
			dis_reg <= `RPA_FLAGS_RST;
			led_test_reg <= 1'b0;
			enable_reg <= `RPA_ENABLE_RST;
			led_reg <= `RPA_FLAGS_RST;
			four_pair_reg <= 1'b0;
			pnum_reg <= `RPA_PNUM_RST;
			eeprom_load_complete_reg <= 1'b0;
			id_err_reg <= 1'b0;
			id_reg <= `RPA_ID_RST;
		end else begin
			page_reg <= page_next;
			port_partitioned_flag_reg <= port_partitioned_flag_next;
			jab_reg <= jab_next;
			dis_reg <= dis_next;
			led_test_reg <= led_test_next;
			enable_reg <= enable_next;
			led_reg <= led_next;
			four_pair_reg <= four_pair_next;
			pnum_reg <= pnum_next;
			eeprom_load_complete_reg <= eeprom_load_complete_next;
			id_err_reg <= id_err_next;
			id_reg <= id_next;
		end
	end

	// read mux, undefined and reserved bits read zero
	always_comb begin
		rvalid_next = reg_read_in;
		rdata_next = rdata_reg;
		if (reg_read_in) begin
			// unmapped or reserved page reads give zero
			rdata_next = '0;
			if (rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_PAGE)) begin
				rdata_next[1:0] = page_reg;
			end else if (rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_PORT_PARTITIONED_FLAG)) begin
				rdata_next[`RPA_PORTS-1:0] = port_partitioned_flag_reg;
			end else if (rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_JAB)) begin
				rdata_next[`RPA_PORTS-1:0] = jab_reg;
			end else if (rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_PORT_ADMINISTRATION)) begin
				rdata_next[`RPA_PORTS-1:0] = dis_reg;
				rdata_next[`RPA_BIT_LED_TEST] = led_test_reg;
			end else if (rpa_reg_sel(reg_addr_in, page_reg, `RPA_OFF_DEVID)) begin
				rdata_next[`RPA_BIT_FOUR_PAIR] = four_pair_reg;
				rdata_next[`RPA_PNUM_LSB +: `RPA_PNUM_W] = pnum_reg;
				rdata_next[`RPA_BIT_EEPROM_LOAD_COMPLETE] = eeprom_load_complete_reg;
				rdata_next[`RPA_BIT_ID_ERR] = id_err_reg;
				rdata_next[`RPA_ID_W-1:0] = id_reg;
			end
		end
	end

	// Read data registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;
	assign port_enable_out = enable_reg;
	assign partition_led_enable_out = led_reg;
	assign repeater_id_field_out = id_reg;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	sequence s_port_administration_test_write;
		wr_port_administration && reg_wdata_in[`RPA_BIT_LED_TEST];
	endsequence

	chk_page_write: assert property (wr_page |=> page_reg == $past(reg_wdata_in[1:0]))
		else $error("page select not stored");
	chk_page_any: assert property ((reg_read_in && reg_addr_in == `RPA_OFF_PAGE)
			|=> reg_rvalid_out && reg_rdata_out == {14'h0000, $past(page_reg)})
		else $error("page register not readable on current page");
	chk_port_partitioned_flag_set: assert property ((|port_partitioned_flag_set_in) |=> ((port_partitioned_flag_reg
			& $past(port_partitioned_flag_set_in)) == $past(port_partitioned_flag_set_in)))
		else $error("partition flag not set");
	chk_jab_set: assert property ((|port_jabber_flag_set_in) |=> ((jab_reg
			& $past(port_jabber_flag_set_in)) == $past(port_jabber_flag_set_in)))
		else $error("jabber flag not set");
	chk_status_upper: assert property ((reg_read_in && page_reg == `RPA_PAGE_0
			&& reg_addr_in == `RPA_OFF_JAB) |=> reg_rdata_out[15:12] == 4'h0)
		else $error("jabber upper bits not zero");
	chk_port_administration_hold: assert property (!network_idle_in |=> $stable(port_enable_out))
		else $error("port enable changed outside idle");
	chk_port_administration_apply: assert property (network_idle_in |=> port_enable_out == ~$past(dis_reg))
		else $error("port enable not applied at idle");
	chk_led_test: assert property (s_port_administration_test_write ##1 !wr_port_administration
			|=> partition_led_enable_out == $past(reg_wdata_in[`RPA_PORTS-1:0], 2))
		else $error("partition LED test not following disables");
	chk_four_pair_sticky: assert property ((four_pair_reg
			&& !(wr_devid && !reg_wdata_in[`RPA_BIT_FOUR_PAIR])) |=> four_pair_reg)
		else $error("four-pair flag lost");
	chk_port_num: assert property (rx_port_valid_in |=> pnum_reg == $past(rx_port_num_in))
		else $error("receiving port number not captured");
	chk_eeprom_load_complete: assert property (eeprom_load_complete_in |=> eeprom_load_complete_reg [*2])
		else $error("eeprom done not sticky");
	chk_id_err_set: assert property ((id_reg == `RPA_ID_ILLEGAL || identifier_conflict_in)
			|=> id_err_reg)
		else $error("identifier error not set");
	chk_strap_load: assert property ((!strap_done_reg && settle_reg == `RPA_STRAP_SETTLE)
			|=> repeater_id_field_out == $past(filt_reg[`RPA_ID_W-1:0]))
		else $error("identifier strap not loaded");

endmodule : rpa_port_port_administration_status

`default_nettype wire
